// ---- core/rhp_pkg.sv ----
// Purpose: Constants for the root hub port status and power register bank
// Assumes: One 32-bit port register per downstream port, 4 ports
// Notes:   Offsets are byte addresses on the register port
package rhp_pkg;

  localparam int          RHP_NUM_PORTS      = 4;
  localparam logic [7:0]  RHP_PORT_BASE      = 8'h54;
  localparam logic [7:0]  RHP_PORT_STRIDE    = 8'h04;
  localparam int          RHP_BIT_CONNECT    = 0;
  localparam int          RHP_BIT_SET_ENABLE = 1;
  localparam int          RHP_BIT_SET_SUSP   = 2;
  localparam int          RHP_BIT_SET_RESET  = 4;
  localparam int          RHP_BIT_POWER      = 8;
  localparam int          RHP_BIT_LOW_SPEED  = 9;
  localparam int          RHP_BIT_CONN_CHG   = 16;
  localparam logic        RHP_RST_POWER      = 1'b0;
  localparam logic        RHP_RST_CONN_CHG   = 1'b0;
  localparam logic        RHP_MODE_GLOBAL    = 1'b0;

  typedef enum logic [1:0] {
    RHP_CMD_NONE  = 2'b00,
    RHP_CMD_SET   = 2'b01,
    RHP_CMD_CLEAR = 2'b10
  } rhp_cmd_t;

endpackage : rhp_pkg

// ---- core/rhp_port.sv ----
// Purpose: One downstream port's connect change and power status state
// Assumes: Commands arrive as one-cycle pulses from the register decoder
// Notes:   Connect input comes from the port's line logic
`timescale 1ns/100ps
module rhp_port
  import rhp_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     rst_i,
  input  wire logic     switching_supported_i,
  input  wire logic     nonremovable_marker_i,
  input  wire logic     current_connect_status_i,
  input  wire logic     hub_reset_done_i,
  input  wire logic     overcurrent_i,
  input  wire logic     recheck_i,
  input  wire logic     clear_change_i,
  input  wire rhp_cmd_t power_cmd_i,
  output logic          connect_change_flag_o,
  output logic          port_power_status_o
);

  typedef struct packed {
    logic conn_q;
    logic change;
    logic power;
  } rhp_port_state_t;

  rhp_port_state_t state;
  rhp_port_state_t next_state;
  logic            conn_event;

  always_comb begin
    next_state = state;
    next_state.conn_q = current_connect_status_i;
    conn_event = (current_connect_status_i != state.conn_q) & ~nonremovable_marker_i;
    // Clear first so a same-cycle event still sets
    if (clear_change_i) begin
      next_state.change = 1'b0;
    end
    if (conn_event) begin
      next_state.change = 1'b1;
    end
    if (recheck_i) begin
      next_state.change = 1'b1;
    end
    if (nonremovable_marker_i && hub_reset_done_i) begin
      next_state.change = 1'b1;
    end
    case (power_cmd_i)
      RHP_CMD_SET:   next_state.power = 1'b1;
      RHP_CMD_CLEAR: next_state.power = 1'b0;
      default:       next_state.power = next_state.power;
    endcase
    if (overcurrent_i) begin
      next_state.power = 1'b0;
    end
    if (!switching_supported_i) begin
      next_state.power = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '{conn_q: 1'b0, change: RHP_RST_CONN_CHG, power: RHP_RST_POWER};
    end else begin
      state <= next_state;
    end
  end

  assign connect_change_flag_o = state.change;
  assign port_power_status_o   = state.power;

endmodule : rhp_port

// ---- core/rhp_root_hub_port_status_power.sv ----
// Purpose: Root hub per-port status register bank, connect change and power
// Assumes: Simple synchronous register port, one-cycle write/read strobes
// Notes:   Read data is registered, valid the cycle after the read strobe
//          Per-port power writes act only on ports that the mask selects
//          Bit 8 set wins over bit 9 clear within one write
//          Overcurrent wins over any set; unswitched ports stay powered
`timescale 1ns/100ps
module rhp_root_hub_port_status_power
  import rhp_pkg::*;
(
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     switching_supported_i,
  input  wire logic                     per_port_mode_i,
  input  wire logic [RHP_NUM_PORTS-1:0] per_port_power_mask_i,
  input  wire logic [RHP_NUM_PORTS-1:0] nonremovable_marker_i,
  input  wire logic [RHP_NUM_PORTS-1:0] current_connect_status_i,
  input  wire logic [RHP_NUM_PORTS-1:0] low_speed_attached_i,
  input  wire logic [RHP_NUM_PORTS-1:0] port_enable_status_i,
  input  wire logic [RHP_NUM_PORTS-1:0] port_suspend_status_i,
  input  wire logic [RHP_NUM_PORTS-1:0] port_reset_status_i,
  input  wire logic [RHP_NUM_PORTS-1:0] overcurrent_i,
  input  wire logic                     hub_reset_done_i,
  input  wire logic                     set_global_power_i,
  input  wire logic                     clear_global_power_i,
  output logic      [31:0]              rdata_o,
  output logic                          rvalid_o,
  output logic      [RHP_NUM_PORTS-1:0] port_power_o,
  output logic      [RHP_NUM_PORTS-1:0] port_status_reset_o
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic port_hit(input logic [7:0] a, input int p);
    port_hit = (a == RHP_PORT_BASE + 8'(p) * RHP_PORT_STRIDE);
  endfunction : port_hit

  // Strobes qualified by port
  logic [RHP_NUM_PORTS-1:0] wr_hit;
  logic [RHP_NUM_PORTS-1:0] rd_hit;

  always_comb begin
    for (int p = 0; p < RHP_NUM_PORTS; p++) begin
      wr_hit[p] = wr_i & port_hit(addr_i, p);
      rd_hit[p] = rd_i & port_hit(addr_i, p);
    end
  end

  // ------------------------------------------------------------
  // Write command decode
  // ------------------------------------------------------------
  function automatic logic set_request(input logic [31:0] d);
    set_request = d[RHP_BIT_SET_RESET] | d[RHP_BIT_SET_ENABLE] | d[RHP_BIT_SET_SUSP];
  endfunction : set_request

  function automatic rhp_cmd_t power_cmd(
    input logic        port_cmds,
    input logic        hit,
    input logic [31:0] d,
    input logic        set_global,
    input logic        clear_global
  );
    rhp_cmd_t c;
    c = RHP_CMD_NONE;
    if (port_cmds) begin
      // Set looked at first, so it wins over clear
      if (hit && d[RHP_BIT_POWER]) begin
        c = RHP_CMD_SET;
      end else if (hit && d[RHP_BIT_LOW_SPEED]) begin
        c = RHP_CMD_CLEAR;
      end
    end else begin
      if (set_global) begin
        c = RHP_CMD_SET;
      end else if (clear_global) begin
        c = RHP_CMD_CLEAR;
      end
    end
    power_cmd = c;
  endfunction : power_cmd

  // ------------------------------------------------------------
  // Read word assembly
  // ------------------------------------------------------------
  function automatic logic [31:0] pack_status(
    input logic change,
    input logic low_speed,
    input logic power,
    input logic reset_status,
    input logic suspend,
    input logic enable,
    input logic connect
  );
    logic [31:0] w;
    w                     = 32'h0000_0000;
    w[RHP_BIT_CONN_CHG]   = change;
    w[RHP_BIT_LOW_SPEED]  = low_speed;
    w[RHP_BIT_POWER]      = power;
    w[RHP_BIT_SET_RESET]  = reset_status;
    w[RHP_BIT_SET_SUSP]   = suspend;
    w[RHP_BIT_SET_ENABLE] = enable;
    w[RHP_BIT_CONNECT]    = connect;
    pack_status = w;
  endfunction : pack_status

  typedef struct packed {
    logic [31:0]              rdata;
    logic                     rvalid;
    logic [RHP_NUM_PORTS-1:0] power_q;
    logic [RHP_NUM_PORTS-1:0] status_reset;
  } rhp_top_state_t;

  rhp_top_state_t           state;
  rhp_top_state_t           next_state;
  logic [RHP_NUM_PORTS-1:0] change_flag;
  logic [RHP_NUM_PORTS-1:0] power_status;

  // ------------------------------------------------------------
  // Per-port command decode and state
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RHP_NUM_PORTS; g++) begin : g_port
      logic     hit;
      logic     recheck;
      logic     clear_change;
      logic     use_port_cmds;
      rhp_cmd_t cmd;

      always_comb begin
        hit           = wr_hit[g];
        clear_change  = hit & wdata_i[RHP_BIT_CONN_CHG];
        recheck       = hit & ~current_connect_status_i[g] & set_request(wdata_i);
        use_port_cmds = (per_port_mode_i != RHP_MODE_GLOBAL)
                      & per_port_power_mask_i[g];
        cmd           = power_cmd(use_port_cmds, hit, wdata_i,
                                  set_global_power_i, clear_global_power_i);
      end

      rhp_port u_port (
        .clock_i                  (clock_i),
        .rst_i                    (rst_i),
        .switching_supported_i    (switching_supported_i),
        .nonremovable_marker_i    (nonremovable_marker_i[g]),
        .current_connect_status_i (current_connect_status_i[g]),
        .hub_reset_done_i         (hub_reset_done_i),
        .overcurrent_i            (overcurrent_i[g]),
        .recheck_i                (recheck),
        .clear_change_i           (clear_change),
        .power_cmd_i              (cmd),
        .connect_change_flag_o    (change_flag[g]),
        .port_power_status_o      (power_status[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read mux and power-off status reset
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rvalid = rd_i;
    next_state.power_q = power_status;
    next_state.status_reset = ~power_status;
    if (rd_i) begin
      next_state.rdata = 32'h0000_0000;
      for (int p = 0; p < RHP_NUM_PORTS; p++) begin
        if (rd_hit[p]) begin
          next_state.rdata = pack_status(
            change_flag[p],
            low_speed_attached_i[p],
            power_status[p],
            port_reset_status_i[p],
            port_suspend_status_i[p],
            port_enable_status_i[p],
            current_connect_status_i[p]
          );
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '{rdata: 32'h0000_0000, rvalid: 1'b0,
                 power_q: '0, status_reset: '1};
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata_o             = state.rdata;
  assign rvalid_o            = state.rvalid;
  assign port_power_o        = state.power_q;
  assign port_status_reset_o = state.status_reset;

endmodule : rhp_root_hub_port_status_power

// ---- dv/rhp_root_hub_port_status_power_tb.sv ----
// Purpose: Self-checking bench for the port status register bank
// Assumes: Inputs change at the falling edge
// Notes:   Port n sits at 8'h54 + 4n
`timescale 1ns/100ps
module rhp_root_hub_port_status_power_tb import rhp_pkg::*;;
  logic        ck = 0, rst = 1, wr = 0, rd = 0, sw = 1, ppm = 1, hrd = 0, sg = 0, cg = 0;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0]  msk = 4'hF, nrm = 4'h0, current_connect_status = 4'h0, ls = 4'h0, oc = 4'h0;
  logic [31:0] rdo;
  logic        rvo;
  logic [3:0]  pwr, psr;
  int          n_mismatch = 0, checked = 0;
  int          rb[3] = '{1, 2, 4};
  rhp_root_hub_port_status_power i_dut (.clock_i(ck), .rst_i(rst), .wr_i(wr), .rd_i(rd),
    .addr_i(ad), .wdata_i(wd), .switching_supported_i(sw), .per_port_mode_i(ppm),
    .per_port_power_mask_i(msk), .nonremovable_marker_i(nrm), .current_connect_status_i(current_connect_status),
    .low_speed_attached_i(ls), .port_enable_status_i(4'h0), .port_suspend_status_i(4'h0),
    .port_reset_status_i(4'h0), .overcurrent_i(oc), .hub_reset_done_i(hrd),
    .set_global_power_i(sg), .clear_global_power_i(cg), .rdata_o(rdo), .rvalid_o(rvo),
    .port_power_o(pwr), .port_status_reset_o(psr));
  always #4 ck = ~ck;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    ad = a;
    wd = d;
    wr = 1;
    @(negedge ck);
    wr = 0;
    @(negedge ck);
  endtask : wrt
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    ad = a;
    rd = 1;
    @(negedge ck);
    rd = 0;
    chk("rvalid", 32'(rvo), 32'h1);
    chk(n, rdo, e);
    @(negedge ck);
  endtask : rdc
  task automatic pl(ref logic s);
    s = 1;
    @(negedge ck);
    s = 0;
    @(negedge ck);
  endtask : pl
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(negedge ck);
    rst = 0;
    chk("status_reset", 32'(psr), 32'hF);
    rdc(8'h54, 32'h0, "p0_reset");
    for (int p = 0; p < 4; p++)
      wrt(8'h54 + 8'(4 * p), 32'h100);
    chk("power", 32'(pwr), 32'hF);
    chk("status_reset", 32'(psr), 32'h0);
    rdc(8'h5C, 32'h100, "p2_power");
    current_connect_status[0] = 1;
    ls[0] = 1;
    repeat (2) @(negedge ck);
    rdc(8'h54, 32'h10301, "p0_attach");
    wrt(8'h54, 32'h0);
    rdc(8'h54, 32'h10301, "p0_keep");
    wrt(8'h54, 32'h10000);
    rdc(8'h54, 32'h301, "p0_clear");
    wrt(8'h54, 32'h200);
    rdc(8'h54, 32'h201, "p0_off");
    foreach (rb[i]) begin
      wrt(8'h58, 32'(1) << rb[i]);
      rdc(8'h58, 32'h10100, "p1_recheck");
      wrt(8'h58, 32'h10000);
    end
    msk = 4'hB;
    wrt(8'h5C, 32'h200);
    rdc(8'h5C, 32'h100, "p2_masked");
    pl(cg);
    chk("power", 32'(pwr), 32'hA);
    ppm = 0;
    wrt(8'h58, 32'h200);
    chk("power", 32'(pwr), 32'hA);
    pl(sg);
    chk("power", 32'(pwr), 32'hF);
    pl(cg);
    chk("power", 32'(pwr), 32'h0);
    pl(sg);
    oc[3] = 1;
    repeat (2) @(negedge ck);
    oc[3] = 0;
    chk("power", 32'(pwr), 32'h7);
    nrm[3] = 1;
    current_connect_status[3] = 1;
    repeat (2) @(negedge ck);
    rdc(8'h60, 32'h1, "p3_fixed");
    pl(hrd);
    rdc(8'h60, 32'h10001, "p3_hub_reset");
    wrt(8'h60, 32'hFC00);
    rdc(8'h60, 32'h10001, "p3_reserved");
    rdc(8'h00, 32'h0, "unmapped");
    sw = 0;
    repeat (3) @(negedge ck);
    chk("power", 32'(pwr), 32'hF);
    rdc(8'h60, 32'h10101, "p3_unswitched");
    current_connect_status[0] = 0;
    ls[0] = 0;
    repeat (2) @(negedge ck);
    rdc(8'h54, 32'h10100, "p0_detach");
    end_of_test();
  end
endmodule : rhp_root_hub_port_status_power_tb

// ---- dv/rhp_sva.sv ----
// Purpose: Assertions on the port status register bank
// Assumes: Port 0 at 8'h54, 4 ports
// Notes:   Sees top-level ports only
`timescale 1ns/100ps
module rhp_sva
  import rhp_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        switching_supported_i,
  input wire logic        per_port_mode_i,
  input wire logic [3:0]  per_port_power_mask_i,
  input wire logic [3:0]  low_speed_attached_i,
  input wire logic [3:0]  overcurrent_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic [3:0]  port_power_o,
  input wire logic [3:0]  port_status_reset_o
);
  logic own_wr;
  assign own_wr = wr_i && addr_i == 8'h54 && switching_supported_i && per_port_mode_i
                  && per_port_power_mask_i[0] && !overcurrent_i[0];
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_resv; rvalid_o |-> rdata_o[15:10] == 6'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_off; $changed(port_power_o[0]) |-> port_status_reset_o[0] == !port_power_o[0];
  endproperty
  a_off: assert property (p_off) else $error("status reset wrong");
  property p_oc; switching_supported_i && overcurrent_i[3] |-> ##2 !port_power_o[3]; endproperty
  a_oc: assert property (p_oc) else $error("power kept on overcurrent");
  property p_clr; own_wr && wdata_i[9] && !wdata_i[8] |-> ##2 !port_power_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear power ignored");
  property p_set; own_wr && wdata_i[8] |-> ##2 port_power_o[0]; endproperty
  a_set: assert property (p_set) else $error("set power ignored");
  property p_unsup; (!switching_supported_i)[*3] |-> port_power_o == 4'hF; endproperty
  a_unsup: assert property (p_unsup) else $error("power off unswitched");
  property p_ls; rd_i && addr_i == 8'h54 |=> rdata_o[9] == $past(low_speed_attached_i[0]);
  endproperty
  a_ls: assert property (p_ls) else $error("speed bit wrong");
  property p_pwr; rd_i && addr_i == 8'h54 |=> rvalid_o && rdata_o[8] == port_power_o[0];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit wrong");
endmodule : rhp_sva
bind rhp_root_hub_port_status_power rhp_sva i_sva (.clock_i(clock_i), .rst_i(rst_i),
  .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .switching_supported_i(switching_supported_i), .per_port_mode_i(per_port_mode_i),
  .per_port_power_mask_i(per_port_power_mask_i), .low_speed_attached_i(low_speed_attached_i),
  .overcurrent_i(overcurrent_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .port_power_o(port_power_o), .port_status_reset_o(port_status_reset_o));
